//--- rtl/usi_regs.sv
// Transmit status, interrupt enable and flag registers behind the serial host port
`default_nettype none
// Three-stage pin sampler; a change counts once stages two and three agree
module usi_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock, reset, enable
	input  wire logic CLK,
	input  wire logic RST_B,
	input  wire logic CE,
	// Pin and last accepted level
	input  wire logic PIN,
	input  wire logic HELD,
	// Filtered level for this cycle
	output var  logic LEVEL
);
	typedef struct packed {
		logic [2:0] stages;
	} usi_sync_s;

	usi_sync_s s_r;
	usi_sync_s s_nxt;

	// Shift the pin in; frozen while the enable is low
	always_comb begin
		s_nxt = s_r;
		if (CE) begin
			s_nxt.stages = {s_r.stages[1:0], PIN};
		end
	end

	// New level only when the last two stages agree
	always_comb begin
		if (s_r.stages[1] == s_r.stages[2]) begin
			LEVEL = s_r.stages[2];
		end else begin
			LEVEL = HELD;
		end
	end

	// Stage register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			s_r <= '{stages: {3{RST_VAL}}};
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

module usi_regs
	import usi_pkg::*;
#(
	parameter int PTR_W = 3
) (
	// Clock, reset, enable
	input  wire logic             CLK,
	input  wire logic             RST_B,
	input  wire logic             CE,
	// Serial host port
	input  wire logic             CS_B,
	input  wire logic             SCLK,
	input  wire logic             DIN,
	output var  logic             DOUT,
	output var  logic             DOUT_OE,
	// Transmit datapath
	input  wire logic             TX_ACTIVE,
	input  wire logic [PTR_W-1:0] LOAD_QUEUE_POINTER,
	input  wire logic [PTR_W-1:0] XMIT_POINTER,
	input  wire logic             LOAD_ADVANCE,
	output var  logic             LOAD_OVERWRITE,
	// Receive conditions
	input  wire logic [7:0]       RX_COND,
	// Interrupt
	output var  logic             INT_B
);
	import usi_pkg::*;

	typedef struct packed {
		logic       cs_f;
		logic       din_f;
		logic       sclk_f;
		logic [4:0] cnt;
		logic [7:0] shift;
		logic [7:0] addr;
		logic [7:0] rd;
		logic       dout;
		logic       oe;
		logic       ovf;
		logic [7:0] tx_stat;
		logic [7:0] rx_prev;
		logic [7:0] rx_en;
		logic [7:0] tx_en;
		logic [7:0] rx_flg;
		logic [7:0] tx_flg;
		logic       int_b;
	} usi_state_s;

	localparam usi_state_s ST_RST = '{
		cs_f:    1'b1,
		tx_stat: TX_STAT_RST,
		rx_prev: RX_COND_RST,
		rx_en:   EN_RST,
		tx_en:   EN_RST,
		rx_flg:  FLG_RST,
		tx_flg:  FLG_RST,
		int_b:   1'b1,
		default: '0
	};

	usi_state_s s_r;
	usi_state_s s_nxt;

	// Host port pin samplers
	logic cs_lvl;
	logic sclk_lvl;
	logic din_lvl;

	// Chip select idles high
	usi_sync #(
		.RST_VAL (1'b1)
	) cs_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.CE    (CE),
		.PIN   (CS_B),
		.HELD  (s_r.cs_f),
		.LEVEL (cs_lvl)
	);

	// Serial clock idles low
	usi_sync #(
		.RST_VAL (1'b0)
	) sclk_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.CE    (CE),
		.PIN   (SCLK),
		.HELD  (s_r.sclk_f),
		.LEVEL (sclk_lvl)
	);

	// Serial data in
	usi_sync #(
		.RST_VAL (1'b0)
	) din_sync (
		.CLK   (CLK),
		.RST_B (RST_B),
		.CE    (CE),
		.PIN   (DIN),
		.HELD  (s_r.din_f),
		.LEVEL (din_lvl)
	);

	// Read multiplexer; unmapped addresses return zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a, input usi_state_s s);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			A_TX_STAT_RD: v = s.tx_stat & TX_MASK;
			A_RX_EN_RD:   v = s.rx_en & RX_MASK;
			A_TX_EN_RD:   v = s.tx_en & TX_MASK;
			A_RX_FLG_RD:  v = s.rx_flg & RX_MASK;
			A_TX_FLG_RD:  v = s.tx_flg & TX_MASK;
			default:      v = 8'h00;
		endcase
		return v;
	endfunction

	// Next-state logic
	always_comb begin
		logic       cs_n;
		logic       sclk_n;
		logic       rise;
		logic       fall;
		logic       din;
		logic [7:0] byte_in;
		logic       full;
		logic       empty;
		logic [7:0] stat;
		logic [7:0] rx_rise;
		logic [7:0] tx_rise;
		logic       wr;
		logic [7:0] rd_v;
		cs_n    = s_r.cs_f;
		sclk_n  = s_r.sclk_f;
		rise    = 1'b0;
		fall    = 1'b0;
		din     = din_lvl;
		rd_v    = 8'h00;
		byte_in = {s_r.shift[6:0], din};
		full    = 1'b0;
		empty   = 1'b0;
		stat    = 8'h00;
		rx_rise = 8'h00;
		tx_rise = 8'h00;
		wr      = 1'b0;
		s_nxt   = s_r;
		if (CE) begin
			// Filtered pin levels from the samplers
			cs_n        = cs_lvl;
			sclk_n      = sclk_lvl;
			s_nxt.din_f = din_lvl;
			rise = ~cs_n & sclk_n & ~s_r.sclk_f;
			fall = ~cs_n & ~sclk_n & s_r.sclk_f;
			s_nxt.cs_f   = cs_n;
			s_nxt.sclk_f = sclk_n;
			s_nxt.oe     = ~cs_n;

			// Frame bit counting and shifting
			if (cs_n) begin
				s_nxt.cnt = 5'h00;
			end else if (rise && s_r.cnt < FRAME_BITS) begin
				s_nxt.shift = byte_in;
				s_nxt.cnt   = s_r.cnt + 5'h01;
				if (s_r.cnt == ADDR_BITS - 5'h01) begin
					s_nxt.addr = byte_in;
					rd_v       = rd_mux(byte_in, s_r);
					s_nxt.rd   = rd_v;
					s_nxt.dout = rd_v[7];
				end
				if (s_r.cnt == FRAME_BITS - 5'h01 && !s_r.addr[0]) begin
					wr = 1'b1;
				end
			end else if (fall && s_r.cnt > ADDR_BITS && s_r.cnt < FRAME_BITS) begin
				s_nxt.rd   = {s_r.rd[6:0], 1'b0};
				s_nxt.dout = s_r.rd[6];
			end

			// Queue pointer comparisons
			full  = (LOAD_QUEUE_POINTER == XMIT_POINTER - PTR_W'(1));
			empty = (LOAD_QUEUE_POINTER == XMIT_POINTER);

			// Overflow set by a blocked advance, held until the queue is no longer full
			if (LOAD_ADVANCE && full) begin
				s_nxt.ovf = 1'b1;
			end else if (!full) begin
				s_nxt.ovf = 1'b0;
			end

			// Transmit status snapshot
			stat[B_BUSY]  = TX_ACTIVE;
			stat[B_IDLE]  = ~TX_ACTIVE;
			stat[B_OVF]   = s_r.ovf;
			stat[B_FULL]  = full;
			stat[B_AVAIL] = ~full;
			stat[B_EMPTY] = empty;
			s_nxt.tx_stat = stat;

			// Condition rises for flag latching
			rx_rise       = RX_COND & ~s_r.rx_prev & RX_MASK;
			tx_rise       = stat & ~s_r.tx_stat & TX_MASK;
			s_nxt.rx_prev = RX_COND;

			// Register writes; a rise in the same cycle wins over a clear
			s_nxt.rx_flg = s_r.rx_flg | rx_rise;
			s_nxt.tx_flg = s_r.tx_flg | tx_rise;
			if (wr) begin
				unique case (s_r.addr)
					A_RX_EN_WR:  s_nxt.rx_en  = byte_in & RX_MASK;
					A_TX_EN_WR:  s_nxt.tx_en  = byte_in & TX_MASK;
					A_RX_FLG_WR: s_nxt.rx_flg = (s_r.rx_flg & byte_in & RX_MASK) | rx_rise;
					A_TX_FLG_WR: s_nxt.tx_flg = (s_r.tx_flg & byte_in & TX_MASK) | tx_rise;
					default:     s_nxt.rx_en  = s_r.rx_en;
				endcase
			end

			// Interrupt request, active low
			s_nxt.int_b = ~|((s_nxt.rx_flg & s_nxt.rx_en) | (s_nxt.tx_flg & s_nxt.tx_en));
		end
	end

	// State register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign DOUT           = s_r.dout;
	assign DOUT_OE        = s_r.oe;
	assign LOAD_OVERWRITE = s_r.ovf;
	assign INT_B          = s_r.int_b;
endmodule
`default_nettype wire

//--- rtl/usi_pkg.sv
// Constants for the transmit status and interrupt register block
`default_nettype none
package usi_pkg;
	// Host port addresses: even writes, odd reads
	localparam logic [7:0] A_TX_STAT_RD = 8'h03;
	localparam logic [7:0] A_RX_EN_WR   = 8'h04;
	localparam logic [7:0] A_RX_EN_RD   = 8'h05;
	localparam logic [7:0] A_TX_EN_WR   = 8'h06;
	localparam logic [7:0] A_TX_EN_RD   = 8'h07;
	localparam logic [7:0] A_RX_FLG_WR  = 8'h08;
	localparam logic [7:0] A_RX_FLG_RD  = 8'h09;
	localparam logic [7:0] A_TX_FLG_WR  = 8'h0A;
	localparam logic [7:0] A_TX_FLG_RD  = 8'h0B;
	// Transmit status field positions
	localparam int B_BUSY  = 5;
	localparam int B_IDLE  = 4;
	localparam int B_OVF   = 3;
	localparam int B_FULL  = 2;
	localparam int B_AVAIL = 1;
	localparam int B_EMPTY = 0;
	// Implemented bits; reserved bits read zero
	localparam logic [7:0] RX_MASK = 8'hBF;
	localparam logic [7:0] TX_MASK = 8'h3F;
	// Reset values
	localparam logic [7:0] TX_STAT_RST = 8'h13;
	localparam logic [7:0] RX_COND_RST = 8'h11;
	localparam logic [7:0] EN_RST      = 8'h00;
	localparam logic [7:0] FLG_RST     = 8'h00;
	// Serial frame: address byte then data byte
	localparam logic [4:0] ADDR_BITS  = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
endpackage
`default_nettype wire

//--- tb/usi_regs_monitor.sv
// Port checker for the status and interrupt register block
`default_nettype none
module usi_regs_monitor #(parameter int PTR_W = 3) (
	// Clock, reset, enable
	input wire logic             CLK,
	input wire logic             RST_B,
	input wire logic             CE,
	// Serial host port
	input wire logic             CS_B,
	input wire logic             SCLK,
	input wire logic             DIN,
	input wire logic             DOUT,
	input wire logic             DOUT_OE,
	// Transmit datapath and interrupt
	input wire logic             TX_ACTIVE,
	input wire logic             LOAD_ADVANCE,
	input wire logic             LOAD_OVERWRITE,
	input wire logic             INT_B,
	input wire logic [PTR_W-1:0] LOAD_QUEUE_POINTER,
	input wire logic [PTR_W-1:0] XMIT_POINTER,
	// Receive conditions
	input wire logic [7:0]       RX_COND
);
	timeunit 1ns;
	timeprecision 100ps;
	logic full;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Load one behind transmit
	assign full = LOAD_QUEUE_POINTER == PTR_W'(XMIT_POINTER - 1'b1);
	property p_ovf_set; CE && LOAD_ADVANCE && full |=> LOAD_OVERWRITE; endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overwrite not raised");
	property p_ovf_hold; LOAD_OVERWRITE && full |=> LOAD_OVERWRITE; endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overwrite dropped");
	property p_ovf_clr; CE && !full |=> !LOAD_OVERWRITE; endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overwrite stuck");
	property p_ovf_why; $rose(LOAD_OVERWRITE) |-> $past(LOAD_ADVANCE) && $past(full); endproperty
	a_ovf_why: assert property (p_ovf_why) else $error("overwrite without cause");
	property p_oe_off; (CE && CS_B) [*8] |-> !DOUT_OE; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled idle");
	property p_oe_on; (CE && !CS_B) [*8] |-> DOUT_OE; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not enabled");
	property p_dout; ($stable(SCLK) && $stable(CS_B)) [*8] |-> $stable(DOUT); endproperty
	a_dout: assert property (p_dout) else $error("read data moved");
	property p_int; ($stable(SCLK) && $stable(CE) && $stable(RX_COND) && $stable(TX_ACTIVE) && $stable(XMIT_POINTER)
		&& $stable(LOAD_QUEUE_POINTER) && !LOAD_ADVANCE) [*8] |-> $stable(INT_B); endproperty
	a_int: assert property (p_int) else $error("interrupt moved unprompted");
	cover property (!INT_B);
	cover property ($rose(LOAD_OVERWRITE));
	cover property ($fell(DOUT_OE));
endmodule
`default_nettype wire

//--- tb/usi_host.sv
// Host serial master model, mode 0
`default_nettype none
module usi_host (
	// Pins driven towards the device
	output var  logic CS_B,
	output var  logic SCLK,
	output var  logic DIN,
	// Read data from the device
	input  wire logic DOUT
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {CS_B, SCLK, DIN} = 3'h4;
	// One frame: address then data, read bits taken on rises 9..16
	task automatic xfer(input logic [7:0] a, d, output logic [7:0] q);
		logic [15:0] f = {a, d};
		#3 CS_B = 1'h0;
		#100;
		for (int i = 15; i >= 0; i--) begin
			DIN = f[i];
			#62.5 SCLK = 1'h1;
			if (i < 8) q[i] = DOUT;
			#62.5 SCLK = 1'h0;
		end
		#100 CS_B = 1'h1;
		DIN = ~DIN; // No stale bit once released
		#100;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the status and interrupt registers
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import usi_pkg::*;
	logic       CLK = 1'h0, RST_B = 1'h0, CE = 1'h1, TX_ACTIVE = 1'h0, LOAD_ADVANCE = 1'h0;
	logic       CS_B, SCLK, DIN, DOUT, DOUT_OE, LOAD_OVERWRITE, INT_B;
	logic [2:0] LOAD_QUEUE_POINTER = 3'h0, XMIT_POINTER = 3'h0;
	logic [7:0] RX_COND = 8'h00, q;
	int         failures = 0, samples_checked = 0;
	// System clock
	always #5 CLK = ~CLK;
	// Device and host
	usi_regs usi_regs_inst (
		.CLK                (CLK),
		.RST_B              (RST_B),
		.CE                 (CE),
		.CS_B               (CS_B),
		.SCLK               (SCLK),
		.DIN                (DIN),
		.DOUT               (DOUT),
		.DOUT_OE            (DOUT_OE),
		.TX_ACTIVE          (TX_ACTIVE),
		.LOAD_QUEUE_POINTER (LOAD_QUEUE_POINTER),
		.XMIT_POINTER       (XMIT_POINTER),
		.LOAD_ADVANCE       (LOAD_ADVANCE),
		.LOAD_OVERWRITE     (LOAD_OVERWRITE),
		.RX_COND            (RX_COND),
		.INT_B              (INT_B)
	);
	usi_host usi_host_inst (
		.CS_B (CS_B),
		.SCLK (SCLK),
		.DIN  (DIN),
		.DOUT (DOUT)
	);
	task automatic chk(input string n, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, e);
		usi_host_inst.xfer(a, 8'h00, q);
		chk($sformatf("reg %h", a), q, e);
	endtask
	task automatic wr(input logic [7:0] a, d);
		usi_host_inst.xfer(a, d, q);
	endtask
	// Set datapath, pulse advance, then check overwrite and status
	task automatic st(input logic a, input logic [2:0] l, x, input logic v, input logic [7:0] e);
		@(posedge CLK);
		TX_ACTIVE <= a;
		LOAD_QUEUE_POINTER <= l;
		XMIT_POINTER <= x;
		LOAD_ADVANCE <= v;
		@(posedge CLK);
		LOAD_ADVANCE <= 1'h0;
		repeat (3) @(posedge CLK);
		chk("overwrite", 8'(LOAD_OVERWRITE), 8'(e[B_OVF]));
		rd(A_TX_STAT_RD, e);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#300us;
		failures++;
		complete_run;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge CLK);
		RST_B <= 1'h1;
		repeat (4) @(posedge CLK);
		rd(A_TX_STAT_RD, TX_STAT_RST);
		rd(A_RX_EN_RD, EN_RST);
		rd(A_TX_EN_RD, EN_RST);
		rd(A_RX_FLG_RD, FLG_RST);
		$display("test reset done");
		wr(A_RX_EN_WR, 8'hFF);
		rd(A_RX_EN_RD, RX_MASK);
		wr(A_TX_EN_WR, 8'hFF);
		rd(A_TX_EN_RD, TX_MASK);
		rd(8'h0F, 8'h00);
		$display("test enables done");
		st(1'h1, 3'h2, 3'h3, 1'h0, 8'h24);
		st(1'h1, 3'h2, 3'h3, 1'h1, 8'h2C);
		st(1'h0, 3'h7, 3'h0, 1'h0, 8'h1C);
		st(1'h0, 3'h5, 3'h5, 1'h0, 8'h13);
		st(1'h1, 3'h1, 3'h5, 1'h0, 8'h22);
		$display("test status done");
		rd(A_TX_FLG_RD, TX_MASK);
		chk("int", 8'(INT_B), 8'h00);
		wr(A_TX_FLG_WR, 8'h00);
		wr(A_RX_EN_WR, 8'h00);
		@(posedge CLK);
		RX_COND <= 8'hFF;
		repeat (4) @(posedge CLK);
		rd(A_RX_FLG_RD, RX_MASK);
		chk("int masked", 8'(INT_B), 8'h01);
		wr(A_RX_EN_WR, 8'h80);
		chk("int raised", 8'(INT_B), 8'h00);
		wr(A_RX_FLG_WR, 8'h7F);
		rd(A_RX_FLG_RD, 8'h3F);
		chk("int cleared", 8'(INT_B), 8'h01);
		$display("test flags done");
		// Frame sent while the enable is low is lost
		@(posedge CLK);
		CE <= 1'h0;
		wr(A_RX_EN_WR, 8'h00);
		@(posedge CLK);
		CE <= 1'h1;
		repeat (4) @(posedge CLK);
		rd(A_RX_EN_RD, 8'h80);
		chk("int frozen", 8'(INT_B), 8'h01);
		$display("test freeze done");
		// Second reset in mid-run
		@(posedge CLK);
		RST_B <= 1'h0;
		repeat (16) @(posedge CLK);
		RST_B <= 1'h1;
		repeat (4) @(posedge CLK);
		rd(A_RX_EN_RD, EN_RST);
		rd(A_TX_EN_RD, EN_RST);
		chk("int reset", 8'(INT_B), 8'h01);
		$display("test second reset done");
		complete_run;
	end
endmodule
bind usi_regs usi_regs_monitor #(
	.PTR_W (PTR_W)
) usi_regs_monitor_inst (
	.CLK                (CLK),
	.RST_B              (RST_B),
	.CE                 (CE),
	.CS_B               (CS_B),
	.SCLK               (SCLK),
	.DIN                (DIN),
	.DOUT               (DOUT),
	.DOUT_OE            (DOUT_OE),
	.TX_ACTIVE          (TX_ACTIVE),
	.LOAD_ADVANCE       (LOAD_ADVANCE),
	.LOAD_OVERWRITE     (LOAD_OVERWRITE),
	.INT_B              (INT_B),
	.LOAD_QUEUE_POINTER (LOAD_QUEUE_POINTER),
	.XMIT_POINTER       (XMIT_POINTER),
	.RX_COND            (RX_COND)
);
`default_nettype wire
